// ---- rtl/pmx_pkg.sv ----
// Package: constants for the multifunction pin mux.
// Assumes one clock domain and plain-port control bits.
package pmx_pkg;

  // ****************************************
  // Pin group sizes
  // ****************************************
  localparam int PMX_STD_PINS = 5;
  localparam int PMX_FAST_PINS = 4;
  localparam int PMX_REG_PINS = 4;

  // ****************************************
  // Index of each pin inside its group vector
  // ****************************************
  localparam int PMX_STD_P0 = 0;
  localparam int PMX_STD_P1 = 1;
  localparam int PMX_STD_P2 = 2;
  localparam int PMX_STD_P3 = 3;
  localparam int PMX_STD_P9 = 4;
  localparam int PMX_REG_P5 = 0;
  localparam int PMX_REG_P6 = 1;
  localparam int PMX_REG_P7 = 2;
  localparam int PMX_REG_P8 = 3;
  localparam int PMX_SPI_DOUT = 0;
  localparam int PMX_SPI_DIN = 1;
  localparam int PMX_SPI_SCLK = 2;
  localparam int PMX_SPI_SSEL = 3;

  // ****************************************
  // Function select codes
  // ****************************************
  localparam logic PMX_SEL_GPIO = 1'b0;
  localparam logic PMX_SEL_ALT = 1'b1;

  // ****************************************
  // Reset values of the pad drivers
  // ****************************************
  localparam logic PMX_RST_OUT = 1'b0;
  localparam logic PMX_STD_RST_OE = 1'b1;
  localparam logic PMX_FAST_RST_OE = 1'b0;
  localparam logic PMX_REG_RST_OE = 1'b1;

  // ****************************************
  // Audio control register view
  // ****************************************
  localparam logic [7:0] PMX_I2S_CTRL_OFS = 8'h2b;
  localparam int PMX_JC_OFF_BIT = 7;

endpackage : pmx_pkg

// ---- rtl/pmx_pad_cell.sv ----
// One shared pad: chooses GPIO or alternate drive, syncs the pad input.
// Assumes pad_i is asynchronous and rst_n_i is already synchronised.
`timescale 1ns/10ps
`default_nettype none
module pmx_pad_cell
  import pmx_pkg::*;
#(
  parameter logic RST_OE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sel_alt_i,
  input wire logic func_en_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic alt_out_i,
  input wire logic alt_oe_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic gpio_in_o,
  output logic alt_in_o
);

  logic next_out;
  logic next_oe;
  logic sync1;
  logic sync2;

  // ****************************************
  // Output select
  // ****************************************
  // Alternate source wins the pad
  always_comb begin
    next_out = PMX_RST_OUT;
    next_oe = 1'b0;
    if (sel_alt_i == PMX_SEL_ALT) begin
      next_out = alt_out_i;
      next_oe = alt_oe_i;
    end else if (func_en_i) begin
      next_out = gpio_out_i;
      next_oe = gpio_oe_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= PMX_RST_OUT;
      pad_oe_o <= RST_OE;
    end else begin
      pad_o <= next_out;
      pad_oe_o <= next_oe;
    end
  end

  // ****************************************
  // Input sync and steering
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pad_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_in_o <= 1'b0;
      alt_in_o <= 1'b0;
    end else begin
      gpio_in_o <= sync2 & func_en_i & (sel_alt_i == PMX_SEL_GPIO);
      alt_in_o <= sync2 & (sel_alt_i == PMX_SEL_ALT);
    end
  end

endmodule : pmx_pad_cell
`default_nettype wire

// ---- rtl/pmx_pin_mux.sv ----
// Top of the multifunction pin mux: standard, fast and register-only pads.
// Assumes select bits come from control registers on this clock.
//
// Contract
// - Standard pins 0, 1, 2, 3 and 9 come out of reset as GPIO driven low.
// - Each shared pin's function comes from a select bit, never a strap.
// - The four fast pins come out of reset as GPIO in tri-state.
// - Fast GPIO works only in dual-link mode and is off in single-link mode.
// - Fast pins 0 to 3 share pads with SPI data-out, data-in, clock and select.
// - Register-only pins 5 to 8 default to GPIO low and are seen only by registers.
// - Register-only pin 7 can drive the slave audio word clock out.
// - Register-only pin 8 can drive the slave audio bit clock out.
// - Register-only pins 6 and 5 can drive slave audio lanes A and B out.
// - Pins 1 and 9 can carry master word and system clocks, 2 and 3 lanes C and D.
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_mux
  import pmx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dual_link_i,
  input wire logic [7:0] i2s_ctrl_i,
  input wire logic [PMX_STD_PINS-1:0] std_sel_i,
  input wire logic [PMX_STD_PINS-1:0] std_gpio_out_i,
  input wire logic [PMX_STD_PINS-1:0] std_gpio_oe_i,
  output logic [PMX_STD_PINS-1:0] std_gpio_in_o,
  input wire logic master_audio_data_i,
  input wire logic master_audio_word_clock_i,
  input wire logic master_audio_sys_clock_i,
  input wire logic audio_data_lane_c_i,
  input wire logic audio_data_lane_d_i,
  input wire logic [PMX_STD_PINS-1:0] std_pad_i,
  output logic [PMX_STD_PINS-1:0] std_pad_o,
  output logic [PMX_STD_PINS-1:0] std_pad_oe_o,
  input wire logic [PMX_FAST_PINS-1:0] fast_sel_i,
  input wire logic [PMX_FAST_PINS-1:0] fast_gpio_out_i,
  input wire logic [PMX_FAST_PINS-1:0] fast_gpio_oe_i,
  output logic [PMX_FAST_PINS-1:0] fast_gpio_in_o,
  input wire logic [PMX_FAST_PINS-1:0] spi_out_i,
  input wire logic [PMX_FAST_PINS-1:0] spi_oe_i,
  output logic [PMX_FAST_PINS-1:0] spi_in_o,
  input wire logic [PMX_FAST_PINS-1:0] fast_pad_i,
  output logic [PMX_FAST_PINS-1:0] fast_pad_o,
  output logic [PMX_FAST_PINS-1:0] fast_pad_oe_o,
  input wire logic [PMX_REG_PINS-1:0] reg_sel_i,
  input wire logic [PMX_REG_PINS-1:0] reg_only_out_i,
  input wire logic [PMX_REG_PINS-1:0] reg_only_oe_i,
  output logic [PMX_REG_PINS-1:0] reg_only_in_o,
  input wire logic audio_data_lane_a_i,
  input wire logic audio_data_lane_b_i,
  input wire logic slave_audio_word_clock_i,
  input wire logic slave_audio_bit_clock_i,
  input wire logic [PMX_REG_PINS-1:0] reg_pad_i,
  output logic [PMX_REG_PINS-1:0] reg_pad_o,
  output logic [PMX_REG_PINS-1:0] reg_pad_oe_o,
  output logic slave_clk_cfg_err_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_ff;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_ff[1];

  // ****************************************
  // Alternate sources
  // ****************************************
  logic [PMX_STD_PINS-1:0] std_alt;
  logic [PMX_REG_PINS-1:0] reg_alt;
  logic [PMX_FAST_PINS-1:0] fast_en;

  // Master data, clocks and lanes C, D
  always_comb begin
    std_alt = 5'h00;
    std_alt[PMX_STD_P0] = master_audio_data_i;
    std_alt[PMX_STD_P1] = master_audio_word_clock_i;
    std_alt[PMX_STD_P2] = audio_data_lane_c_i;
    std_alt[PMX_STD_P3] = audio_data_lane_d_i;
    std_alt[PMX_STD_P9] = master_audio_sys_clock_i;
  end

  always_comb begin
    reg_alt = 4'h0;
    reg_alt[PMX_REG_P5] = audio_data_lane_b_i;
    reg_alt[PMX_REG_P6] = audio_data_lane_a_i;
    reg_alt[PMX_REG_P7] = slave_audio_word_clock_i;
    reg_alt[PMX_REG_P8] = slave_audio_bit_clock_i;
  end

  // Fast GPIO gated by dual link
  assign fast_en = {PMX_FAST_PINS{dual_link_i}};

  // ****************************************
  // Pad cells
  // ****************************************
  // Select bits steer each pad
  genvar gi;
  generate
    for (gi = 0; gi < PMX_STD_PINS; gi++) begin : g_std
      pmx_pad_cell #(.RST_OE(PMX_STD_RST_OE)) u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sel_alt_i(std_sel_i[gi]),
        .func_en_i(1'b1),
        .gpio_out_i(std_gpio_out_i[gi]),
        .gpio_oe_i(std_gpio_oe_i[gi]),
        .alt_out_i(std_alt[gi]),
        .alt_oe_i(1'b1),
        .pad_i(std_pad_i[gi]),
        .pad_o(std_pad_o[gi]),
        .pad_oe_o(std_pad_oe_o[gi]),
        .gpio_in_o(std_gpio_in_o[gi]),
        .alt_in_o()
      );
    end
    // Fast pads reset tri-state, SPI shared
    for (gi = 0; gi < PMX_FAST_PINS; gi++) begin : g_fast
      pmx_pad_cell #(.RST_OE(PMX_FAST_RST_OE)) u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sel_alt_i(fast_sel_i[gi]),
        .func_en_i(fast_en[gi]),
        .gpio_out_i(fast_gpio_out_i[gi]),
        .gpio_oe_i(fast_gpio_oe_i[gi]),
        .alt_out_i(spi_out_i[gi]),
        .alt_oe_i(spi_oe_i[gi]),
        .pad_i(fast_pad_i[gi]),
        .pad_o(fast_pad_o[gi]),
        .pad_oe_o(fast_pad_oe_o[gi]),
        .gpio_in_o(fast_gpio_in_o[gi]),
        .alt_in_o(spi_in_o[gi])
      );
    end
    // Register-only pads, read back to registers only
    for (gi = 0; gi < PMX_REG_PINS; gi++) begin : g_reg
      pmx_pad_cell #(.RST_OE(PMX_REG_RST_OE)) u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sel_alt_i(reg_sel_i[gi]),
        .func_en_i(1'b1),
        .gpio_out_i(reg_only_out_i[gi]),
        .gpio_oe_i(reg_only_oe_i[gi]),
        .alt_out_i(reg_alt[gi]),
        .alt_oe_i(1'b1),
        .pad_i(reg_pad_i[gi]),
        .pad_o(reg_pad_o[gi]),
        .pad_oe_o(reg_pad_oe_o[gi]),
        .gpio_in_o(reg_only_in_o[gi]),
        .alt_in_o()
      );
    end
  endgenerate

  // ****************************************
  // Jitter cleaner check
  // ****************************************
  // Hardware cannot force the cleaner off; it only flags the hazard
  // Slave clocks need cleaner disabled
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slave_clk_cfg_err_o <= 1'b0;
    end else begin
      slave_clk_cfg_err_o <= (reg_sel_i[PMX_REG_P7] | reg_sel_i[PMX_REG_P8])
                             & ~i2s_ctrl_i[PMX_JC_OFF_BIT];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Pads hold reset values one edge past release, so attempts start on rst_n
  // Standard pads low after reset
  a_std_reset_low: assert property (@(posedge clk_i) $rose(rst_n) |->
    (std_pad_o == 5'h00) && (std_pad_oe_o == 5'h1f))
    else $error("standard pads not driven low at reset release");

  a_fast_reset_tri: assert property (@(posedge clk_i) $rose(rst_n) |->
    (fast_pad_oe_o == 4'h0))
    else $error("fast pads driven at reset release");

  a_fast_reset_quiet: assert property (@(posedge clk_i) !rst_n |->
    (fast_pad_oe_o == 4'h0) && (fast_gpio_in_o == 4'h0) && (spi_in_o == 4'h0))
    else $error("fast pads active during reset");

  a_reg_reset_low: assert property (@(posedge clk_i) $rose(rst_n) |->
    (reg_pad_o == 4'h0) && (reg_only_in_o == 4'h0))
    else $error("register-only pads not low at reset release");

  // Master word clock on pin 1
  a_master_wclk: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && std_sel_i[PMX_STD_P1] |=> std_pad_oe_o[PMX_STD_P1]
    && (std_pad_o[PMX_STD_P1] == $past(master_audio_word_clock_i)))
    else $error("pin 1 does not carry master word clock");

  a_master_sclk: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && std_sel_i[PMX_STD_P9] |=> std_pad_oe_o[PMX_STD_P9]
    && (std_pad_o[PMX_STD_P9] == $past(master_audio_sys_clock_i)))
    else $error("pin 9 does not carry system clock");

  // GPIO follows engine when not selected
  a_std_gpio_path: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && !std_sel_i[PMX_STD_P2] |=> (std_pad_o[PMX_STD_P2] == $past(std_gpio_out_i[PMX_STD_P2]))
    && (std_pad_oe_o[PMX_STD_P2] == $past(std_gpio_oe_i[PMX_STD_P2])))
    else $error("pin 2 GPIO output not forwarded");

  a_slave_wclk: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && reg_sel_i[PMX_REG_P7] |=> reg_pad_oe_o[PMX_REG_P7]
    && (reg_pad_o[PMX_REG_P7] == $past(slave_audio_word_clock_i)))
    else $error("pin 7 does not carry slave word clock");

  a_slave_bclk: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && reg_sel_i[PMX_REG_P8] |=> reg_pad_oe_o[PMX_REG_P8]
    && (reg_pad_o[PMX_REG_P8] == $past(slave_audio_bit_clock_i)))
    else $error("pin 8 does not carry slave bit clock");

  // Lanes A and B on pins 6 and 5
  a_slave_lanes: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && reg_sel_i[PMX_REG_P6] && reg_sel_i[PMX_REG_P5] |=>
    (reg_pad_o[PMX_REG_P6] == $past(audio_data_lane_a_i))
    && (reg_pad_o[PMX_REG_P5] == $past(audio_data_lane_b_i)))
    else $error("pins 6 and 5 do not carry lanes A and B");

  // Lanes A and B drive their pads
  a_slave_lane_oe: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && reg_sel_i[PMX_REG_P6] && reg_sel_i[PMX_REG_P5] |=>
    reg_pad_oe_o[PMX_REG_P6] && reg_pad_oe_o[PMX_REG_P5])
    else $error("pins 6 and 5 not driven as lane outputs");

  a_jitter_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && reg_sel_i[PMX_REG_P8] && !i2s_ctrl_i[PMX_JC_OFF_BIT] |=> slave_clk_cfg_err_o)
    else $error("jitter cleaner hazard not flagged");

  // Hazard flag clear once cleaner is off
  a_jitter_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && i2s_ctrl_i[PMX_JC_OFF_BIT] |=> !slave_clk_cfg_err_o)
    else $error("jitter cleaner hazard flagged while cleaner off");

  generate
    for (gi = 0; gi < PMX_FAST_PINS; gi++) begin : g_fast_chk
      // No fast GPIO drive in single link
      a_fast_single_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!dual_link_i && !fast_sel_i[gi]) [*2] |=>
        !fast_pad_oe_o[gi] && !fast_gpio_in_o[gi])
        else $error("fast GPIO active in single link");

      // Fast GPIO drive forwarded in dual link
      a_fast_gpio_path: assert property (@(posedge clk_i) disable iff (!rst_n)
        rst_n && dual_link_i && !fast_sel_i[gi] |=>
        (fast_pad_o[gi] == $past(fast_gpio_out_i[gi])) && (fast_pad_oe_o[gi] == $past(fast_gpio_oe_i[gi])))
        else $error("fast GPIO output not forwarded in dual link");

      a_spi_share: assert property (@(posedge clk_i) disable iff (!rst_n)
        rst_n && fast_sel_i[gi] |=> (fast_pad_o[gi] == $past(spi_out_i[gi]))
        && (fast_pad_oe_o[gi] == $past(spi_oe_i[gi])))
        else $error("fast pad not owned by SPI");

      a_spi_in_cut: assert property (@(posedge clk_i) disable iff (!rst_n)
        !fast_sel_i[gi] [*2] |=> !spi_in_o[gi])
        else $error("SPI input live while pad is GPIO");
    end
    for (gi = 0; gi < PMX_STD_PINS; gi++) begin : g_std_chk
      a_gpio_cut: assert property (@(posedge clk_i) disable iff (!rst_n)
        std_sel_i[gi] [*2] |=> !std_gpio_in_o[gi] && std_pad_oe_o[gi])
        else $error("GPIO path still live on alternate pin");
    end
    for (gi = 0; gi < PMX_REG_PINS; gi++) begin : g_reg_chk
      a_reg_gpio_path: assert property (@(posedge clk_i) disable iff (!rst_n)
        rst_n && !reg_sel_i[gi] |=> (reg_pad_o[gi] == $past(reg_only_out_i[gi])))
        else $error("register-only GPIO output not forwarded");

      // Register GPIO input cut while alternate
      a_reg_cut: assert property (@(posedge clk_i) disable iff (!rst_n)
        reg_sel_i[gi] [*2] |=> !reg_only_in_o[gi] && reg_pad_oe_o[gi])
        else $error("register GPIO path still live on alternate pin");
    end
  endgenerate

endmodule : pmx_pin_mux
`default_nettype wire

// ---- sim/pmx_board_model.sv ----
// Board logic on one group of shared pads: resolves each pad wire.
// Assumes the weak pulldown wins only when nobody drives the pad.
`timescale 1ns/10ps
`default_nettype none
module pmx_board_model #(
  parameter int W = 4
) (
  input wire logic [W-1:0] pad_out_i,
  input wire logic [W-1:0] pad_oe_i,
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] drv_en_i,
  output logic [W-1:0] pad_in_o
);
  // ****************************************
  // Wire resolution
  // ****************************************
  // Released pad takes the board drive, else falls to the pulldown, never keeps the last value
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (pad_oe_i[k]) begin
        pad_in_o[k] = pad_out_i[k];
      end else if (drv_en_i[k]) begin
        pad_in_o[k] = drv_i[k];
      end else begin
        pad_in_o[k] = 1'b0;
      end
    end
  end
endmodule : pmx_board_model
`default_nettype wire

// ---- sim/pmx_pin_mux_tb_top.sv ----
// Testbench of the pin mux: pad drive, pad read-back and error flag.
// Assumes one clock and board models on all three pad groups.
`timescale 1ns/10ps
`default_nettype none
module pmx_pin_mux_tb_top
  import pmx_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i, dual_link_i;
  logic [7:0] i2s_ctrl_i;
  logic [4:0] std_sel_i, std_gpio_out_i, std_gpio_oe_i, std_drv, std_en;
  logic master_audio_data_i, master_audio_word_clock_i, master_audio_sys_clock_i;
  logic audio_data_lane_c_i, audio_data_lane_d_i, audio_data_lane_a_i, audio_data_lane_b_i;
  logic slave_audio_word_clock_i, slave_audio_bit_clock_i;
  logic [3:0] fast_sel_i, fast_gpio_out_i, fast_gpio_oe_i, spi_out_i, spi_oe_i, fast_drv, fast_en;
  logic [3:0] reg_sel_i, reg_only_out_i, reg_only_oe_i, reg_drv, reg_en;
  logic [4:0] std_gpio_in_o, std_pad_i, std_pad_o, std_pad_oe_o;
  logic [3:0] fast_gpio_in_o, spi_in_o, fast_pad_i, fast_pad_o, fast_pad_oe_o;
  logic [3:0] reg_only_in_o, reg_pad_i, reg_pad_o, reg_pad_oe_o;
  logic slave_clk_cfg_err_o;
  int err_total = 0;
  int total_checks = 0;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  pmx_pin_mux pmx_pin_mux_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .dual_link_i(dual_link_i),
    .i2s_ctrl_i(i2s_ctrl_i), .std_sel_i(std_sel_i), .std_gpio_out_i(std_gpio_out_i),
    .std_gpio_oe_i(std_gpio_oe_i), .std_gpio_in_o(std_gpio_in_o), .master_audio_data_i(master_audio_data_i),
    .master_audio_word_clock_i(master_audio_word_clock_i), .master_audio_sys_clock_i(master_audio_sys_clock_i),
    .audio_data_lane_c_i(audio_data_lane_c_i), .audio_data_lane_d_i(audio_data_lane_d_i),
    .std_pad_i(std_pad_i), .std_pad_o(std_pad_o), .std_pad_oe_o(std_pad_oe_o), .fast_sel_i(fast_sel_i),
    .fast_gpio_out_i(fast_gpio_out_i), .fast_gpio_oe_i(fast_gpio_oe_i), .fast_gpio_in_o(fast_gpio_in_o),
    .spi_out_i(spi_out_i), .spi_oe_i(spi_oe_i), .spi_in_o(spi_in_o), .fast_pad_i(fast_pad_i),
    .fast_pad_o(fast_pad_o), .fast_pad_oe_o(fast_pad_oe_o), .reg_sel_i(reg_sel_i),
    .reg_only_out_i(reg_only_out_i), .reg_only_oe_i(reg_only_oe_i), .reg_only_in_o(reg_only_in_o),
    .audio_data_lane_a_i(audio_data_lane_a_i), .audio_data_lane_b_i(audio_data_lane_b_i),
    .slave_audio_word_clock_i(slave_audio_word_clock_i), .slave_audio_bit_clock_i(slave_audio_bit_clock_i),
    .reg_pad_i(reg_pad_i), .reg_pad_o(reg_pad_o), .reg_pad_oe_o(reg_pad_oe_o),
    .slave_clk_cfg_err_o(slave_clk_cfg_err_o));
  pmx_board_model #(.W(5)) std_board_inst (.pad_out_i(std_pad_o), .pad_oe_i(std_pad_oe_o),
    .drv_i(std_drv), .drv_en_i(std_en), .pad_in_o(std_pad_i));
  pmx_board_model #(.W(4)) fast_board_inst (.pad_out_i(fast_pad_o), .pad_oe_i(fast_pad_oe_o),
    .drv_i(fast_drv), .drv_en_i(fast_en), .pad_in_o(fast_pad_i));
  pmx_board_model #(.W(4)) reg_board_inst (.pad_out_i(reg_pad_o), .pad_oe_i(reg_pad_oe_o),
    .drv_i(reg_drv), .drv_en_i(reg_en), .pad_in_o(reg_pad_i));

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask : step

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Drive changes land one edge later; two edges leave margin
  task automatic set_std(input logic [4:0] sel, input logic [4:0] out, input logic [4:0] oe);
    std_sel_i = sel;
    std_gpio_out_i = out;
    std_gpio_oe_i = oe;
    step(2);
  endtask : set_std

  task automatic set_fast(input logic dl, input logic [3:0] sel, input logic [3:0] out, input logic [3:0] oe);
    dual_link_i = dl;
    fast_sel_i = sel;
    fast_gpio_out_i = out;
    fast_gpio_oe_i = oe;
    step(2);
  endtask : set_fast

  task automatic set_reg(input logic [3:0] sel, input logic [3:0] out, input logic [3:0] oe);
    reg_sel_i = sel;
    reg_only_out_i = out;
    reg_only_oe_i = oe;
    step(2);
  endtask : set_reg

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst_n_i, dual_link_i, i2s_ctrl_i, std_sel_i, std_gpio_out_i, std_gpio_oe_i, std_drv, std_en} = '0;
    {master_audio_data_i, master_audio_word_clock_i, master_audio_sys_clock_i} = '0;
    {audio_data_lane_a_i, audio_data_lane_b_i, audio_data_lane_c_i, audio_data_lane_d_i} = '0;
    {slave_audio_word_clock_i, slave_audio_bit_clock_i, spi_out_i, spi_oe_i} = '0;
    {fast_sel_i, fast_gpio_out_i, fast_gpio_oe_i, reg_sel_i, reg_only_out_i, reg_only_oe_i} = '0;
    fast_drv = 4'hf;
    fast_en = 4'hf;
    {reg_drv, reg_en} = '0;
    step(10);
    chk("std_pad_o", 8'h00, std_pad_o);
    chk("std_pad_oe_o", 8'h1f, std_pad_oe_o);
    chk("fast_pad_oe_o", 8'h00, fast_pad_oe_o);
    chk("fast_gpio_in_o", 8'h00, fast_gpio_in_o);
    chk("reg_pad_o", 8'h00, reg_pad_o);
    chk("reg_pad_oe_o", 8'h0f, reg_pad_oe_o);
    step(6);
    rst_n_i = 1'b1;
    step(4);
    $display("test reset done");
    set_std(5'h00, 5'h1f, 5'h1f);
    chk("std_pad_o", 8'h1f, std_pad_o);
    set_std(5'h00, 5'h00, 5'h00);
    std_drv = 5'h15;
    std_en = 5'h1f;
    step(4);
    chk("std_gpio_in_o", 8'h15, std_gpio_in_o);
    std_en = 5'h00;
    {master_audio_sys_clock_i, audio_data_lane_d_i, master_audio_word_clock_i} = 3'b111;
    set_std(5'h1f, 5'h00, 5'h1f);
    chk("std_pad_o", 8'h1a, std_pad_o);
    chk("std_pad_oe_o", 8'h1f, std_pad_oe_o);
    step(2);
    chk("std_gpio_in_o", 8'h00, std_gpio_in_o);
    {master_audio_sys_clock_i, audio_data_lane_d_i, master_audio_word_clock_i} = 3'b000;
    {audio_data_lane_c_i, master_audio_data_i} = 2'b11;
    step(2);
    chk("std_pad_o", 8'h05, std_pad_o);
    $display("test standard pins done");
    set_fast(1'b0, 4'h0, 4'hf, 4'hf);
    step(2);
    chk("fast_pad_oe_o", 8'h00, fast_pad_oe_o);
    chk("fast_pad_o", 8'h00, fast_pad_o);
    chk("fast_gpio_in_o", 8'h00, fast_gpio_in_o);
    set_fast(1'b1, 4'h0, 4'h0, 4'h0);
    step(2);
    chk("fast_gpio_in_o", 8'h0f, fast_gpio_in_o);
    chk("spi_in_o", 8'h00, spi_in_o);
    set_fast(1'b1, 4'h0, 4'hf, 4'hf);
    chk("fast_pad_o", 8'h0f, fast_pad_o);
    fast_drv = 4'h4;
    spi_out_i = 4'h9;
    spi_oe_i = 4'hb;
    set_fast(1'b1, 4'hf, 4'hf, 4'hf);
    chk("fast_pad_oe_o", 8'h0b, fast_pad_oe_o);
    chk("fast_pad_o masked", 8'h09, fast_pad_o & fast_pad_oe_o);
    step(2);
    chk("spi_in_o", 8'h0d, spi_in_o);
    chk("fast_gpio_in_o", 8'h00, fast_gpio_in_o);
    $display("test fast pins done");
    set_reg(4'h0, 4'h5, 4'hf);
    chk("reg_pad_o", 8'h05, reg_pad_o);
    reg_drv = 4'ha;
    reg_en = 4'hf;
    set_reg(4'h0, 4'h5, 4'h0);
    step(2);
    chk("reg_only_in_o", 8'h0a, reg_only_in_o);
    reg_en = 4'h0;
    i2s_ctrl_i = 8'h80;
    {audio_data_lane_b_i, slave_audio_word_clock_i} = 2'b11;
    set_reg(4'hf, 4'ha, 4'hf);
    chk("reg_pad_o", 8'h05, reg_pad_o);
    chk("reg_pad_oe_o", 8'h0f, reg_pad_oe_o);
    chk("slave_clk_cfg_err_o", 8'h00, slave_clk_cfg_err_o);
    chk("reg_only_in_o", 8'h00, reg_only_in_o);
    {audio_data_lane_b_i, slave_audio_word_clock_i} = 2'b00;
    {audio_data_lane_a_i, slave_audio_bit_clock_i} = 2'b11;
    step(2);
    chk("reg_pad_o", 8'h0a, reg_pad_o);
    // Misordered setup must raise the flag
    i2s_ctrl_i = 8'h00;
    step(2);
    chk("slave_clk_cfg_err_o", 8'h01, slave_clk_cfg_err_o);
    $display("test register-only pins done");
    // Reset in mid-run drops every alternate drive at once
    rst_n_i = 1'b0;
    step(2);
    chk("std_pad_o", 8'h00, std_pad_o);
    chk("std_pad_oe_o", 8'h1f, std_pad_oe_o);
    chk("fast_pad_oe_o", 8'h00, fast_pad_oe_o);
    chk("reg_pad_o", 8'h00, reg_pad_o);
    chk("slave_clk_cfg_err_o", 8'h00, slave_clk_cfg_err_o);
    rst_n_i = 1'b1;
    step(4);
    chk("std_pad_o", 8'h05, std_pad_o);
    chk("reg_pad_o", 8'h0a, reg_pad_o);
    chk("slave_clk_cfg_err_o", 8'h01, slave_clk_cfg_err_o);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : pmx_pin_mux_tb_top
`default_nettype wire
